// ===== rtl/crl_pkg.sv
package crl_pkg;
    // ---------------------------------------------------------------
    // register map (word index; byte address is index * 4)
    // ---------------------------------------------------------------
    localparam int ADDR_W = 4;
    localparam logic [ADDR_W-1:0] IDX_LADDER_CTRL0 = 4'h0;
    localparam logic [ADDR_W-1:0] IDX_LADDER_CTRL1 = 4'h1;
    localparam logic [ADDR_W-1:0] IDX_CMP1_CTRL0 = 4'h2;
    localparam logic [ADDR_W-1:0] IDX_CMP1_CTRL1 = 4'h3;
    localparam logic [ADDR_W-1:0] IDX_CMP2_CTRL0 = 4'h4;
    localparam logic [ADDR_W-1:0] IDX_CMP2_CTRL1 = 4'h5;
    localparam logic [ADDR_W-1:0] IDX_CMP_SUMMARY = 4'h6;
    localparam logic [ADDR_W-1:0] IDX_CMP_IRQ = 4'h7;
    // ---------------------------------------------------------------
    // field positions
    // ---------------------------------------------------------------
    localparam int BIT_LADDER_ON = 7;
    localparam int BIT_LADDER_PIN1 = 5;
    localparam int BIT_LADDER_PIN2 = 4;
    localparam int BIT_LADDER_TOP = 2;
    localparam int LEVEL_W = 5;
    localparam logic [7:0] MASK_LADDER_CTRL0 = 8'hB4;
    localparam logic [7:0] MASK_LADDER_CTRL1 = 8'h1F;
    localparam logic [7:0] MASK_CMP_CTRL0 = 8'hB7;
    localparam logic [7:0] MASK_CMP_CTRL1 = 8'hF7;
    localparam int BIT_CMP_ON = 7;
    localparam int BIT_CMP_RESULT = 6;
    localparam int BIT_CMP_PIN = 5;
    localparam int BIT_CMP_INV = 4;
    localparam int BIT_CMP_SPEED = 2;
    localparam int BIT_CMP_HYST = 1;
    localparam int BIT_CMP_SYNC = 0;
    localparam int BIT_CMP_RISE = 7;
    localparam int BIT_CMP_FALL = 6;
    localparam int POS_LO = 4;
    localparam int NEG_LO = 0;
    localparam logic [7:0] RST_LADDER = 8'h00;
    localparam logic [7:0] RST_CMP_CTRL0 = 8'h04;
    localparam logic [7:0] RST_CMP_CTRL1 = 8'h00;
    localparam int NUM_CMP = 2;
    // ---------------------------------------------------------------
    // channel codes
    // ---------------------------------------------------------------
    localparam logic [1:0] POS_PIN = 2'h0;
    localparam logic [1:0] POS_LADDER = 2'h1;
    localparam logic [1:0] POS_FIXED = 2'h2;
    localparam logic [1:0] POS_GROUND = 2'h3;

    // one-hot analog mux enables; all zero connects nothing
    typedef struct packed {
        logic [3:0] posOneHot;
        logic [7:0] negOneHot;
    } crl_mux_t;

    typedef struct packed {
        logic on;
        logic [LEVEL_W-1:0] level;
        logic topIsRefPin;
        logic pin1Drive;
        logic pin2Drive;
    } crl_ladder_t;

    typedef struct packed {
        logic pinOut;
        logic pinOe;
        logic portOverride;
    } crl_pin_t;
endpackage

// ===== rtl/crl_comparator_and_ref_ladder_ctrl.sv
`timescale 1ns/1ps
// Behaviour
// [R1] ladder powered only while ladder_on bit 7 is one
// [R2] five-bit level code picks one of 32 ladder taps
// [R3] bits 5 and 4 connect ladder voltage to pin 1 and pin 2
// [R4] driven ladder pin has digital driver, pull-up, input detector forced off
// [R5] bit 2 picks reference pin as ladder top, else supply
// [R6] reset turns ladder off, drops both pins, clears level code
// [R7] waking from sleep leaves ladder control register untouched
// [R8] unimplemented ladder bits read as zero
// [R9] software should switch the ladder off before sleep
// [R10] each comparator has its own two control registers
// [R11] comparator enable runs it; clearing disconnects all inputs
// [R12] two-bit positive field picks pin, ladder, fixed reference or ground
// [R13] three-bit negative field picks the inverting input source
// [R14] result readable in own control bit and in shared mirror register
// [R15] result on pin only with pin enable, direction clear, comparator on
// [R16] pin enable overrides port latch regardless of comparator enable
// [R17] sync result to logic cells, converter, timer; async to waveform gen
// [R18] internal result registered every cycle; pin output not registered unless sync bit set
// [R19] result is one when plus exceeds minus, inverted by invert bit
// [R20] software sets analog-select and direction bits for analog pins
// [R21] positive codes: 11 ground, 10 fixed reference, 01 ladder
// [R22] sync bit latches timer and pin result on timer clock falling edge
// [R23] rise and fall enables set sticky flag; only software clears it
// [R24] positive code 00 selects the positive analog pin
// [R25] channel selects all deselected while comparator is disabled
module crl_comparator_and_ref_ladder_ctrl (
    input wire logic clk, // 250 MHz instruction clock
    input wire logic rst_n, // async reset, active low
    input wire logic wake, // sleep wake event, no register effect
    input wire logic [31:0] wb_adr_i, // wishbone byte address
    input wire logic [31:0] wb_dat_i, // wishbone write data
    output logic [31:0] wb_dat_o, // wishbone read data
    input wire logic [3:0] wb_sel_i, // byte enables
    input wire logic wb_we_i, // write
    input wire logic wb_cyc_i, // cycle
    input wire logic wb_stb_i, // strobe
    output logic wb_ack_o, // acknowledge
    output logic wb_err_o, // unmapped address
    input wire logic [1:0] cmpRaw, // analog comparator outputs, async
    input wire logic timerClk, // timer 1 source clock after prescaler
    input wire logic [1:0] pinDirection, // direction bit per comparator pin, 1 input
    input wire logic [1:0] portLatch, // port data latch per comparator pin
    output crl_pkg::crl_ladder_t ladder, // ladder analog controls
    output logic [1:0] ladderPinBlock, // digital functions off on ladder pins
    output crl_pkg::crl_mux_t [1:0] cmpMux, // analog input mux enables
    output logic [1:0] cmpPower, // comparator core enable
    output logic [1:0] cmpSpeed, // comparator speed select
    output logic [1:0] cmpHyst, // comparator hysteresis enable
    output logic [1:0] cmpSyncOut, // sync result to logic cells, converter, timer
    output logic [1:0] cmpAsyncOut, // async result to waveform generator
    output crl_pkg::crl_pin_t [1:0] cmpPin, // comparator pin drive
    output logic [1:0] cmpIrqFlag // sticky edge flags
);
    import crl_pkg::*;

    // ---------------------------------------------------------------
    // bus decode
    // ---------------------------------------------------------------
    logic [7:0] ladderCtrl0_ff, ladderCtrl1_ff;
    logic [7:0] cmpCtrl0_ff [NUM_CMP];
    logic [7:0] cmpCtrl1_ff [NUM_CMP];
    logic [1:0] irqFlag_ff;
    logic ack_ff, err_ff;
    logic [31:0] rdData_ff;
    logic [ADDR_W-1:0] regIdx;
    logic busReq, addrHit, wrLane0, wrStrobe;
    logic [7:0] wrByte;

    assign regIdx = wb_adr_i[ADDR_W+1:2];
    assign busReq = wb_cyc_i & wb_stb_i & ~ack_ff & ~err_ff;
    assign addrHit = (wb_adr_i[31:ADDR_W+2] == '0) && (regIdx <= IDX_CMP_IRQ);
    assign wrLane0 = wb_we_i & wb_sel_i[0];
    assign wrStrobe = busReq & addrHit & wrLane0;
    assign wrByte = wb_dat_i[7:0];

    logic wrLad0, wrLad1, wrIrq;
    logic [1:0] wrCmp0, wrCmp1;
    assign wrLad0 = wrStrobe && (regIdx == IDX_LADDER_CTRL0);
    assign wrLad1 = wrStrobe && (regIdx == IDX_LADDER_CTRL1);
    assign wrCmp0[0] = wrStrobe && (regIdx == IDX_CMP1_CTRL0);
    assign wrCmp1[0] = wrStrobe && (regIdx == IDX_CMP1_CTRL1);
    assign wrCmp0[1] = wrStrobe && (regIdx == IDX_CMP2_CTRL0);
    assign wrCmp1[1] = wrStrobe && (regIdx == IDX_CMP2_CTRL1);
    assign wrIrq = wrStrobe && (regIdx == IDX_CMP_IRQ);

    // ---------------------------------------------------------------
    // ladder registers
    // ---------------------------------------------------------------
    // wake is deliberately not used: only reset and writes change these
    // [R6] reset clears ladder
    // [R7] wake leaves contents
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ladderCtrl0_ff <= RST_LADDER;
            ladderCtrl1_ff <= RST_LADDER;
        end else begin
            // [R8] unimplemented masked
            if (wrLad0) ladderCtrl0_ff <= wrByte & MASK_LADDER_CTRL0;
            if (wrLad1) ladderCtrl1_ff <= wrByte & MASK_LADDER_CTRL1;
        end
    end

    // [R1] ladder power
    assign ladder.on = ladderCtrl0_ff[BIT_LADDER_ON];
    // [R2] tap select
    assign ladder.level = ladderCtrl1_ff[LEVEL_W-1:0];
    // [R5] top source
    assign ladder.topIsRefPin = ladderCtrl0_ff[BIT_LADDER_TOP];
    // [R3] pin connect
    assign ladder.pin1Drive = ladderCtrl0_ff[BIT_LADDER_PIN1];
    assign ladder.pin2Drive = ladderCtrl0_ff[BIT_LADDER_PIN2];
    // [R4] digital functions off
    assign ladderPinBlock = {ladder.pin2Drive, ladder.pin1Drive};

    // ---------------------------------------------------------------
    // timer clock edge detect (pin-domain input, two-stage sync first)
    // ---------------------------------------------------------------
    logic tmrMeta_ff, tmrSync_ff, tmrPrev_ff, tmrFall;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tmrMeta_ff <= 1'b0;
            tmrSync_ff <= 1'b0;
            tmrPrev_ff <= 1'b0;
        end else begin
            tmrMeta_ff <= timerClk;
            tmrSync_ff <= tmrMeta_ff;
            tmrPrev_ff <= tmrSync_ff;
        end
    end
    assign tmrFall = tmrPrev_ff & ~tmrSync_ff;

    // ---------------------------------------------------------------
    // per-comparator logic
    // ---------------------------------------------------------------
    logic [1:0] resultSync;
    logic [1:0] nxt_irqFlag;
    logic [1:0] edgeHit;

    // [R10] independent control per comparator
    for (genvar c = 0; c < NUM_CMP; c++) begin : g_cmp
        logic rawMeta_ff, rawSync_ff, result_ff, prevResult_ff, tmrLatch_ff;
        logic on, inv, pinEn, syncMode, polRaw, pinValue, pinDrv;
        logic [1:0] posSel;
        logic [2:0] negSel;

        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                cmpCtrl0_ff[c] <= RST_CMP_CTRL0;
                cmpCtrl1_ff[c] <= RST_CMP_CTRL1;
            end else begin
                if (wrCmp0[c]) cmpCtrl0_ff[c] <= wrByte & MASK_CMP_CTRL0;
                if (wrCmp1[c]) cmpCtrl1_ff[c] <= wrByte & MASK_CMP_CTRL1;
            end
        end

        assign on = cmpCtrl0_ff[c][BIT_CMP_ON];
        assign inv = cmpCtrl0_ff[c][BIT_CMP_INV];
        assign pinEn = cmpCtrl0_ff[c][BIT_CMP_PIN];
        assign syncMode = cmpCtrl0_ff[c][BIT_CMP_SYNC];
        assign posSel = cmpCtrl1_ff[c][POS_LO+1:POS_LO];
        assign negSel = cmpCtrl1_ff[c][NEG_LO+2:NEG_LO];
        // [R11] enable powers core
        assign cmpPower[c] = on;
        assign cmpSpeed[c] = cmpCtrl0_ff[c][BIT_CMP_SPEED];
        assign cmpHyst[c] = cmpCtrl0_ff[c][BIT_CMP_HYST];

        // [R12] positive mux
        // [R21] code decode
        // [R24] code 00 pin
        // [R25] deselect when off
        assign cmpMux[c].posOneHot = on ? (4'h1 << posSel) : 4'h0;
        // [R13] negative mux
        // [R11] inputs disconnected
        assign cmpMux[c].negOneHot = on ? (8'h01 << negSel) : 8'h00;

        // a disabled core reads low; polarity still applies, so toggling
        // invert while off can raise an edge flag as software expects
        // [R19] polarity applied
        assign polRaw = (on & cmpRaw[c]) ^ inv;
        // [R17] async consumer
        assign cmpAsyncOut[c] = polRaw;

        // [R18] per-cycle latch
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                rawMeta_ff <= 1'b0;
                rawSync_ff <= 1'b0;
                result_ff <= 1'b0;
                prevResult_ff <= 1'b0;
                tmrLatch_ff <= 1'b0;
            end else begin
                // gate after the synchroniser so the async pin meets a bare flop first
                rawMeta_ff <= cmpRaw[c];
                rawSync_ff <= rawMeta_ff;
                result_ff <= (on & rawSync_ff) ^ inv;
                prevResult_ff <= result_ff;
                // [R22] timer falling edge latch
                if (tmrFall) tmrLatch_ff <= result_ff;
            end
        end
        assign resultSync[c] = result_ff;

        // [R17] sync consumers
        // [R22] sync mode select
        assign cmpSyncOut[c] = syncMode ? tmrLatch_ff : result_ff;

        // [R18] pin path unlatched unless sync mode
        assign pinValue = syncMode ? tmrLatch_ff : polRaw;
        // [R15] pin drive gating
        assign pinDrv = pinEn & on & ~pinDirection[c];
        // [R16] override ignores enable
        assign cmpPin[c].portOverride = pinEn;
        assign cmpPin[c].pinOut = pinEn ? pinValue : portLatch[c];
        assign cmpPin[c].pinOe = pinDrv | (~pinEn & ~pinDirection[c]);

        // [R23] edge detect
        assign edgeHit[c] = (cmpCtrl1_ff[c][BIT_CMP_RISE] & result_ff & ~prevResult_ff)
            | (cmpCtrl1_ff[c][BIT_CMP_FALL] & ~result_ff & prevResult_ff);
        // set wins over a same-cycle software clear
        assign nxt_irqFlag[c] = edgeHit[c] | (wrIrq & ~wrByte[c] ? 1'b0 : irqFlag_ff[c]);
    end

    // ---------------------------------------------------------------
    // interrupt flags
    // ---------------------------------------------------------------
    // [R23] sticky flags
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) irqFlag_ff <= 2'h0;
        else irqFlag_ff <= nxt_irqFlag;
    end
    assign cmpIrqFlag = irqFlag_ff;

    // ---------------------------------------------------------------
    // read mux and answer
    // ---------------------------------------------------------------
    logic [7:0] rdByte;
    logic [7:0] cmpRd0 [NUM_CMP];
    for (genvar c = 0; c < NUM_CMP; c++) begin : g_rd
        // [R14] result in control bit
        assign cmpRd0[c] = cmpCtrl0_ff[c] | (8'(resultSync[c]) << BIT_CMP_RESULT);
    end

    always_comb begin
        rdByte = 8'h00;
        unique case (regIdx)
            IDX_LADDER_CTRL0: rdByte = ladderCtrl0_ff;
            IDX_LADDER_CTRL1: rdByte = ladderCtrl1_ff;
            IDX_CMP1_CTRL0: rdByte = cmpRd0[0];
            IDX_CMP1_CTRL1: rdByte = cmpCtrl1_ff[0];
            IDX_CMP2_CTRL0: rdByte = cmpRd0[1];
            IDX_CMP2_CTRL1: rdByte = cmpCtrl1_ff[1];
            // [R14] shared mirror
            IDX_CMP_SUMMARY: rdByte = {6'h00, resultSync};
            IDX_CMP_IRQ: rdByte = {6'h00, irqFlag_ff};
            default: rdByte = 8'h00;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ack_ff <= 1'b0;
            err_ff <= 1'b0;
            rdData_ff <= 32'h0;
        end else begin
            ack_ff <= busReq & addrHit;
            err_ff <= busReq & ~addrHit;
            rdData_ff <= {24'h000000, rdByte};
        end
    end
    assign wb_ack_o = ack_ff;
    assign wb_err_o = err_ff;
    assign wb_dat_o = rdData_ff;
endmodule

// ===== verif/crl_sva.sv
`timescale 1ns/1ps
module crl_sva (
    input wire logic clk, // clock
    input wire logic rst_n, // reset
    input wire logic [31:0] wb_adr_i, // address
    input wire logic wb_we_i, // write
    input wire logic wb_cyc_i, // cycle
    input wire logic wb_stb_i, // strobe
    input wire logic wb_ack_o, // ack
    input wire logic wb_err_o, // error
    input wire logic [1:0] pinDirection, // pin direction
    input wire crl_pkg::crl_ladder_t ladder, // ladder
    input wire logic [1:0] ladderPinBlock, // pin block
    input wire crl_pkg::crl_mux_t [1:0] cmpMux, // mux
    input wire logic [1:0] cmpPower, // power
    input wire logic [1:0] cmpSyncOut, // result
    input wire crl_pkg::crl_pin_t [1:0] cmpPin, // pins
    input wire logic [1:0] cmpIrqFlag // flags
);
    import crl_pkg::*;
    logic flagClr;
    assign flagClr = wb_cyc_i && wb_stb_i && wb_we_i && wb_adr_i[5:2] == IDX_CMP_IRQ;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o
        |=> wb_ack_o ^ wb_err_o) else $error("bus answer missing");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    a_pin_block: assert property (ladderPinBlock == {ladder.pin2Drive, ladder.pin1Drive})
        else $error("pin block wrong");
    a_reset_clean: assert property ($rose(rst_n) |-> ladder == 9'h000 && cmpPower == 2'h0)
        else $error("not clean after reset");
    a_mux_off: assert property (!cmpPower[0] |-> cmpMux[0] == 12'h000)
        else $error("mux live while off");
    a_pos_onehot: assert property (cmpPower[0] |-> $onehot(cmpMux[0].posOneHot))
        else $error("positive select not one-hot");
    a_pin_dir: assert property (pinDirection[0] |-> !cmpPin[0].pinOe)
        else $error("pin driven as input");
    a_flag_clear: assert property ($fell(cmpIrqFlag[0]) |-> $past(flagClr))
        else $error("flag cleared without write");
    a_flag_cause: assert property ($rose(cmpIrqFlag[0]) |->
        $past(cmpSyncOut[0]) != $past(cmpSyncOut[0], 2)) else $error("flag without edge");
    c_write: cover property (wb_ack_o && $past(wb_we_i));
    c_error: cover property (wb_err_o);
    c_flag: cover property ($rose(cmpIrqFlag[0]));
endmodule

bind crl_comparator_and_ref_ladder_ctrl crl_sva u_sva (.clk(clk), .rst_n(rst_n),
    .wb_adr_i(wb_adr_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .pinDirection(pinDirection),
    .ladder(ladder), .ladderPinBlock(ladderPinBlock), .cmpMux(cmpMux),
    .cmpPower(cmpPower), .cmpSyncOut(cmpSyncOut), .cmpPin(cmpPin), .cmpIrqFlag(cmpIrqFlag));

// ===== verif/crl_analog_model.sv
`timescale 1ns/1ps
module crl_analog_model #(
    parameter int FIXED_MV = 1024,
    parameter int SUPPLY_MV = 3300
) (
    input wire crl_pkg::crl_ladder_t ladder, // ladder controls
    input wire crl_pkg::crl_mux_t [1:0] cmpMux, // input mux
    input wire logic [1:0] cmpPower, // core enables
    input wire logic [1:0][11:0] pinMv, // plus pin level
    input wire logic [1:0][11:0] negMv, // minus source level
    input wire logic [11:0] refMv, // reference pin level
    output logic [1:0] cmpRaw, // core outputs
    output logic timerClk // timer clock, free running
);
    import crl_pkg::*;
    initial begin
        timerClk = 1'b0;
        forever #7 timerClk = ~timerClk;
    end
    // tap is span times code over 32, dead when off
    always_comb begin
        int top;
        int lad;
        top = ladder.topIsRefPin ? int'(refMv) : SUPPLY_MV;
        lad = ladder.on ? top * int'(ladder.level) / 32 : 0;
        for (int c = 0; c < 2; c++) begin
            cmpRaw[c] = cmpPower[c] && ((cmpMux[c].posOneHot[0] ? int'(pinMv[c]) :
                cmpMux[c].posOneHot[1] ? lad : cmpMux[c].posOneHot[2] ? FIXED_MV : 0)
                > int'(negMv[c]));
        end
    end
endmodule

// ===== verif/tb.sv
`timescale 1ns/1ps
module tb;
    import crl_pkg::*;
    localparam int FIXED_MV = 1024;
    localparam int SUPPLY_MV = 3300;
    logic clk, rst_n, wake, wbWe, wbCyc, wbStb, wbAck, wbErr, timerClk, erSeen;
    logic [31:0] wbAdr, wbDat, wbRdat, seed, r;
    logic [3:0] wbSel;
    logic [1:0] cmpRaw, pinDirection, portLatch, ladderPinBlock, cmpPower, cmpSpeed, cmpHyst;
    logic [1:0] cmpSyncOut, cmpAsyncOut, cmpIrqFlag, code;
    logic [1:0][11:0] pinMv, negMv;
    logic [11:0] refMv;
    logic [7:0] q;
    logic [7:0] shadow [8];
    crl_ladder_t ladder;
    crl_mux_t [1:0] cmpMux;
    crl_pin_t [1:0] cmpPin;
    int failures, testsRun, cycles, i, c;
    crl_comparator_and_ref_ladder_ctrl u_dut (.clk(clk), .rst_n(rst_n), .wake(wake),
        .wb_adr_i(wbAdr), .wb_dat_i(wbDat), .wb_dat_o(wbRdat), .wb_sel_i(wbSel),
        .wb_we_i(wbWe), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_ack_o(wbAck),
        .wb_err_o(wbErr), .cmpRaw(cmpRaw), .timerClk(timerClk), .pinDirection(pinDirection),
        .portLatch(portLatch), .ladder(ladder), .ladderPinBlock(ladderPinBlock),
        .cmpMux(cmpMux), .cmpPower(cmpPower), .cmpSpeed(cmpSpeed), .cmpHyst(cmpHyst),
        .cmpSyncOut(cmpSyncOut), .cmpAsyncOut(cmpAsyncOut), .cmpPin(cmpPin),
        .cmpIrqFlag(cmpIrqFlag));
    crl_analog_model #(.FIXED_MV(FIXED_MV), .SUPPLY_MV(SUPPLY_MV)) u_analog (
        .ladder(ladder), .cmpMux(cmpMux), .cmpPower(cmpPower), .pinMv(pinMv),
        .negMv(negMv), .refMv(refMv), .cmpRaw(cmpRaw), .timerClk(timerClk));
    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function logic [7:0] msk(input int n);
        case (n)
            0: return MASK_LADDER_CTRL0;
            1: return MASK_LADDER_CTRL1;
            2, 4: return MASK_CMP_CTRL0;
            3, 5: return MASK_CMP_CTRL1;
            default: return 8'h00;
        endcase
    endfunction
    function logic expCmp(input int n);
        int vp;
        int top;
        top = shadow[0][2] ? int'(refMv) : SUPPLY_MV;
        case (shadow[3 + 2 * n][5:4])
            2'h0: vp = int'(pinMv[n]);
            2'h1: vp = shadow[0][7] ? top * int'(shadow[1][4:0]) / 32 : 0;
            2'h2: vp = FIXED_MV;
            default: vp = 0;
        endcase
        return (shadow[2 + 2 * n][7] && vp > int'(negMv[n])) ^ shadow[2 + 2 * n][4];
    endfunction
    task chk(input logic [31:0] got, input logic [31:0] exp);
        testsRun++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // waits for ack or err with no assumed latency
    task bus(input logic [3:0] idx, input logic w, input logic [7:0] d, input logic s0);
        int n;
        n = 0;
        @(posedge clk);
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= w;
        wbAdr <= {26'h0, idx, 2'h0};
        wbDat <= {24'h0, d};
        wbSel <= {3'h7, s0};
        do begin
            @(posedge clk);
            n++;
        end while (wbAck !== 1'b1 && wbErr !== 1'b1 && n < 20);
        q = wbRdat[7:0];
        erSeen = wbErr;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        if (n >= 20) failures++;
    endtask
    task wr(input int n, input logic [7:0] d);
        bus(4'(n), 1'b1, d, 1'b1);
        shadow[n] = d & msk(n);
    endtask
    task rd(input int n, input logic [7:0] e);
        bus(4'(n), 1'b0, 8'h00, 1'b1);
        chk(q, e);
    endtask
    task end_of_test();
        $display("checks %0d mismatches %0d", testsRun, failures);
        if (failures == 0 && testsRun > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            end_of_test();
        end
    end
    initial begin
        {rst_n, wake, wbWe, wbCyc, wbStb, wbAdr, wbDat, wbSel} = '0;
        {pinDirection, portLatch, pinMv, negMv} = '0;
        seed = 32'd62718;
        refMv = 12'h9C4;
        foreach (shadow[n]) shadow[n] = (n == 2 || n == 4) ? RST_CMP_CTRL0 : 8'h00;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        for (int k = 0; k < 8; k++) rd(k, shadow[k]);
        chk(cmpSpeed, 2'h3);
        bus(4'h8, 1'b1, 8'hFF, 1'b1);
        chk(erSeen, 1'b1);
        for (int k = 0; k < 12; k++) begin
            r = rnd();
            i = k % 6;
            // sync bit kept off: the flag checker watches the unlatched result
            if (i == 2 || i == 4) r[7:0] = r[7:0] & 8'h7E;
            wr(i, r[7:0]);
            repeat (4) @(posedge clk);
            rd(i, shadow[i] | {1'b0, shadow[i][4] & (i == 2 || i == 4), 6'h0});
            chk(ladder, {shadow[0][7], shadow[1][4:0], shadow[0][2], shadow[0][5:4]});
            chk(ladderPinBlock, {shadow[0][4], shadow[0][5]});
            chk(cmpMux, 24'h0);
        end
        wr(0, shadow[0] & 8'h7F);
        bus(4'h0, 1'b1, 8'hFF, 1'b0);
        wake <= 1'b1;
        @(posedge clk);
        wake <= 1'b0;
        rd(0, shadow[0]);
        pinDirection <= 2'h3;
        for (int k = 0; k < 16; k++) begin
            r = rnd();
            c = k >> 3;
            code = 2'(k >> 1);
            pinMv[c] <= r[11:0];
            negMv[c] <= r[23:12];
            wr(3 + 2 * c, {2'h0, code, 1'b0, r[26:24]});
            wr(2 + 2 * c, {3'h4, r[28], 4'h4});
            repeat (6) @(posedge clk);
            chk(cmpSyncOut[c], expCmp(c));
            chk(cmpAsyncOut[c], expCmp(c));
            chk(cmpMux[c].posOneHot, 4'h1 << code);
            rd(2 + 2 * c, shadow[2 + 2 * c] | {1'b0, expCmp(c), 6'h0});
            rd(6, {6'h0, expCmp(1), expCmp(0)});
        end
        pinMv[0] <= 12'h000;
        negMv[0] <= 12'h7D0;
        wr(3, 8'h80);
        wr(2, 8'h84);
        repeat (6) @(posedge clk);
        wr(7, 8'h00);
        rd(7, 8'h00);
        pinMv[0] <= 12'hFA0;
        repeat (8) @(posedge clk);
        chk(cmpIrqFlag, 2'h1);
        pinMv[0] <= 12'h000;
        repeat (8) @(posedge clk);
        wr(7, 8'h01);
        rd(7, 8'h01);
        wr(7, 8'h00);
        rd(7, 8'h00);
        for (int k = 0; k < 8; k++) begin
            r = rnd();
            pinDirection <= r[1:0];
            portLatch <= r[3:2];
            pinMv[0] <= r[19:8];
            wr(2, {r[4], 1'b0, r[5], 5'h04});
            repeat (6) @(posedge clk);
            chk({cmpPin[0].pinOe, cmpPin[0].pinOut, cmpPin[0].portOverride},
                {!r[0] && (!r[5] || r[4]), r[5] ? expCmp(0) : r[2], r[5]});
        end
        pinDirection <= 2'h0;
        wr(3, 8'h00);
        wr(2, 8'hA5);
        for (int k = 0; k < 4; k++) begin
            pinMv[0] <= k[0] ? 12'hFA0 : 12'h000;
            repeat (2) @(posedge clk);
            chk(cmpAsyncOut[0], k[0]);
            if (k > 0) chk(cmpPin[0].pinOut, !k[0]);
            repeat (16) @(posedge clk);
            chk(cmpSyncOut[0], k[0]);
            chk(cmpPin[0].pinOut, k[0]);
        end
        wr(0, 8'hB4);
        wr(1, 8'h1F);
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        rd(1, 8'h00);
        chk({ladder, ladderPinBlock}, 11'h000);
        end_of_test();
    end
endmodule
